// [hdl/floppy_override_device_disable_regs.sv]
// forced media change, shadows and function kill switch registers
// What this block does
// - per-drive forced change flags, reset 0x03
// - software sets flags, never clears them
// - step with drive 0 selected clears flag 0
// - step with drive 1 selected clears flag 1
// - change status ORs selected flags and pin
// - floppy rate shadow, bit 5 reserved
// - first serial FIFO control shadow
// - second serial shadow, bits 5:4 reserved
// - kill bits override activate bits, reset 0x00
// - bits 3..7 floppy, midi, ser2, ser1, parallel
// - kill bit 0 forces write protect
// - write protect ORs four terms
// - kill bits 2:1 read zero
module floppy_override_device_disable_regs (
   input  wire logic                      MCLK,
   input  wire logic                      RESETN,
   input  wire logic                      STBY_RESETN,
   input  wire logic                      CE,
   input  wire rt_regs_pkg::reg_req_t     REG_REQ,
   output logic      [7:0]                RD_DATA,
   input  wire rt_regs_pkg::drive_lines_t DRIVE,
   input  wire logic                      MEDIA_CHANGE_IN_N,
   input  wire logic                      WRITE_PROTECT_LINE_N,
   input  wire logic                      LOCK_CONTROL_PIN,
   input  wire logic [1:0]                LOCK_CFG,
   input  wire logic                      FORCE_WP,
   input  wire rt_regs_pkg::shadow_wr_t   SHADOW_WR,
   input  wire logic [4:0]                ACTIVATE,
   output logic                           MEDIA_CHANGE_STATUS,
   output logic                           WRITE_PROTECT_CORE,
   output logic      [4:0]                FUNC_ENABLE,
   output logic                           KILL_LOCKED
);
   import rt_regs_pkg::*;

   localparam logic [7:0] SH_MASK [SHADOWS] = '{RATE_MASK, FIFO_MASK,
                                                 FIFO_MASK};

   logic [DRIVES-1:0]    fmc_q;
   logic [DRIVES-1:0]    fmc_d;
   logic [DRIVES-1:0]    fmc_set;
   logic [DRIVES-1:0]    fmc_clr;
   logic [DRIVES-1:0]    drv_sel;
   logic [7:0]           kill_q;
   logic [7:0]           kill_d;
   logic                 step_q;
   logic                 step_act;
   logic                 step_pulse;
   logic [PIN_SYNCS-1:0] pin_raw;
   logic [PIN_SYNCS-1:0] pin_s;
   logic                 chg_pin_s;
   logic                 wp_pin_s;
   logic                 lock_pin_s;
   logic                 locked;
   logic                 fmc_wr;
   logic                 kill_wr;
   logic [SHADOWS-1:0]   sh_wr;
   logic [7:0]           sh_q [SHADOWS];
   logic [7:0]           rd_mux;
   logic                 chg_d;
   logic                 wp_d;
   logic [FUNCS-1:0]     en_d;
   logic                 rd_data_en;

   // pin inputs into the clock domain
   assign pin_raw = {LOCK_CONTROL_PIN, ~WRITE_PROTECT_LINE_N,
                     ~MEDIA_CHANGE_IN_N};

   pin_sync #(
      .W (PIN_SYNCS)
   ) u_pins (
      .clk   (MCLK),
      .rst_n (RESETN),
      .ce    (CE),
      .d     (pin_raw),
      .q     (pin_s)
   );

   assign chg_pin_s  = pin_s[0];
   assign wp_pin_s   = pin_s[1];
   assign lock_pin_s = pin_s[2];

   // drive lines come from the floppy core, same clock
   assign drv_sel    = {~DRIVE.sel1_n, ~DRIVE.sel0_n};
   assign step_act   = ~DRIVE.step_n;
   assign step_pulse = step_act & ~step_q;

   // address decode
   assign fmc_wr  = REG_REQ.wr && (REG_REQ.addr == FMC_OFS);
   assign locked  = (LOCK_CFG == LOCK_CFG_RO) && lock_pin_s;
   assign kill_wr = REG_REQ.wr && (REG_REQ.addr == KILL_OFS)
                    && !locked;

   // forced media change flags, one per drive
   genvar gi;
   generate
      for (gi = 0; gi < DRIVES; gi++) begin : g_drv
         assign fmc_set[gi] = fmc_wr && REG_REQ.wdata[gi];
         assign fmc_clr[gi] = step_pulse && drv_sel[gi];
         // a set in the same cycle as a clear wins
         assign fmc_d[gi]   = fmc_set[gi] | (fmc_q[gi] & ~fmc_clr[gi]);
      end
   endgenerate

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         fmc_q  <= FMC_RST;
         step_q <= 1'b0;
      end else if (CE) begin
         fmc_q  <= fmc_d;
         step_q <= step_act;
      end
   end

   // function kill switch on the standby reset
   assign kill_d = REG_REQ.wdata & KILL_MASK;

   always_ff @(posedge MCLK or negedge STBY_RESETN) begin
      if (!STBY_RESETN) begin
         kill_q <= KILL_RST;
      end else if (CE && kill_wr) begin
         kill_q <= kill_d;
      end
   end

   // shadows of floppy rate and serial FIFO control
   assign sh_wr = {SHADOW_WR.ser2_wr, SHADOW_WR.ser1_wr, SHADOW_WR.rate_wr};

   generate
      for (gi = 0; gi < SHADOWS; gi++) begin : g_sh
         shadow_reg #(
            .MASK (SH_MASK[gi])
         ) u_sh (
            .clk   (MCLK),
            .rst_n (RESETN),
            .ce    (CE),
            .wr    (sh_wr[gi]),
            .wdata (SHADOW_WR.data),
            .q     (sh_q[gi])
         );
      end
   endgenerate

   // read selection, unmapped reads zero
   assign rd_mux = (REG_REQ.addr == FMC_OFS)  ? {6'h00, fmc_q} :
                   (REG_REQ.addr == RATE_OFS) ? sh_q[0] :
                   (REG_REQ.addr == SER1_OFS) ? sh_q[1] :
                   (REG_REQ.addr == SER2_OFS) ? sh_q[2] :
                   (REG_REQ.addr == KILL_OFS) ? kill_q : 8'h00;
   assign rd_data_en = REG_REQ.rd;

   // outputs toward the floppy core and logical devices
   assign chg_d = (drv_sel[0] & fmc_q[0]) | (drv_sel[1] & fmc_q[1])
                  | chg_pin_s;
   assign wp_d  = (drv_sel[0] & FORCE_WP) | (drv_sel[1] & FORCE_WP)
                  | wp_pin_s | kill_q[KILL_WP_BIT];
   assign en_d  = ACTIVATE & ~kill_q[7:KILL_FN_LSB];

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         RD_DATA             <= 8'h00;
         MEDIA_CHANGE_STATUS <= 1'b0;
         WRITE_PROTECT_CORE  <= 1'b0;
         FUNC_ENABLE         <= 5'h00;
         KILL_LOCKED         <= 1'b0;
      end else if (CE) begin
         RD_DATA             <= rd_data_en ? rd_mux : 8'h00;
         MEDIA_CHANGE_STATUS <= chg_d;
         WRITE_PROTECT_CORE  <= wp_d;
         FUNC_ENABLE         <= en_d;
         KILL_LOCKED         <= locked;
      end
   end

   // checks
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN || !STBY_RESETN);

   fmc_init_a: assert property (
      disable iff (1'b0) $rose(RESETN) |-> fmc_q == FMC_RST)
      else $error("forced change flags not 0x03 after reset");

   sw_set_a: assert property (
      CE && fmc_wr && REG_REQ.wdata[0] |=> fmc_q[0])
      else $error("software write of one did not set flag 0");

   no_sw_clear_a: assert property (
      fmc_q[1] && !(CE && fmc_clr[1]) |=> fmc_q[1])
      else $error("flag 1 lost without a step");

   step_clr0_a: assert property (
      CE && step_pulse && drv_sel[0] && !fmc_set[0]
      |=> !fmc_q[0])
      else $error("step with drive 0 did not clear flag 0");

   step_clr1_a: assert property (
      CE && step_pulse && drv_sel[1] && !fmc_set[1] |=> !fmc_q[1])
      else $error("step with drive 1 did not clear flag 1");

   chg_status_a: assert property (
      CE && fmc_q[0] && drv_sel[0] |=> MEDIA_CHANGE_STATUS)
      else $error("selected forced change not reported");

   chg_pin_a: assert property (
      CE && !MEDIA_CHANGE_IN_N ##1 CE ##1 CE ##1 CE
      |-> MEDIA_CHANGE_STATUS)
      else $error("change pin not reported within three cycles");

   rate_read_a: assert property (
      CE && SHADOW_WR.rate_wr ##1 CE && REG_REQ.rd
      && REG_REQ.addr == RATE_OFS
      |=> RD_DATA == ($past(SHADOW_WR.data, 2) & RATE_MASK))
      else $error("rate shadow read wrong");

   ser1_shadow_a: assert property (
      CE && SHADOW_WR.ser1_wr |=> sh_q[1] == ($past(SHADOW_WR.data)
                                             & FIFO_MASK))
      else $error("first serial shadow not captured");

   ser2_shadow_a: assert property (
      CE && REG_REQ.rd && REG_REQ.addr == SER2_OFS
      |=> RD_DATA[5:4] == 2'h0)
      else $error("second serial shadow reserved bits read nonzero");

   kill_fn_a: assert property (
      CE && kill_q[KILL_FN_LSB + 2] |=> !FUNC_ENABLE[2])
      else $error("second serial still enabled when killed");

   enable_pass_a: assert property (
      CE && !kill_q[KILL_FN_LSB] |=> FUNC_ENABLE[0] == $past(ACTIVATE[0]))
      else $error("floppy enable does not follow activate bit");

   wp_force_a: assert property (
      CE && kill_q[KILL_WP_BIT] |=> WRITE_PROTECT_CORE)
      else $error("kill bit 0 did not force write protect");

   wp_terms_a: assert property (
      CE && !kill_q[KILL_WP_BIT] && !wp_pin_s && !FORCE_WP
      |=> !WRITE_PROTECT_CORE)
      else $error("write protect asserted with no cause");

   kill_rsvd_a: assert property (
      CE && REG_REQ.rd && REG_REQ.addr == KILL_OFS
      |=> RD_DATA[2:1] == 2'h0)
      else $error("reserved kill bits not read as zero");

   kill_lock_a: assert property (
      CE && REG_REQ.wr && REG_REQ.addr == KILL_OFS && locked
      |=> $stable(kill_q))
      else $error("locked kill register was written");

   sw_set1_a: assert property (
      CE && fmc_wr && REG_REQ.wdata[1] |=> fmc_q[1])
      else $error("software write of one did not set flag 1");

   flag0_keep_a: assert property (
      fmc_q[0] && !(CE && fmc_clr[0]) |=> fmc_q[0])
      else $error("flag 0 lost without a step");

   flag0_rise_a: assert property (
      !fmc_q[0] && !(CE && fmc_set[0]) |=> !fmc_q[0])
      else $error("flag 0 set without a software write");

   flag1_rise_a: assert property (
      !fmc_q[1] && !(CE && fmc_set[1]) |=> !fmc_q[1])
      else $error("flag 1 set without a software write");

   fmc_read_a: assert property (
      CE && REG_REQ.rd && REG_REQ.addr == FMC_OFS
      |=> RD_DATA[7:2] == 6'h00)
      else $error("forced change upper bits not read as zero");

   chg_status1_a: assert property (
      CE && fmc_q[1] && drv_sel[1] |=> MEDIA_CHANGE_STATUS)
      else $error("selected forced change on drive 1 not reported");

   chg_quiet_a: assert property (
      CE && !chg_pin_s && !(drv_sel[0] && fmc_q[0])
      && !(drv_sel[1] && fmc_q[1]) |=> !MEDIA_CHANGE_STATUS)
      else $error("change status raised with no cause");

   rate_capture_a: assert property (
      CE && SHADOW_WR.rate_wr
      |=> sh_q[0] == ($past(SHADOW_WR.data) & RATE_MASK))
      else $error("rate shadow not captured");

   rate_hold_a: assert property (
      !(CE && SHADOW_WR.rate_wr) |=> $stable(sh_q[0]))
      else $error("rate shadow changed without its strobe");

   rate_rsvd_a: assert property (
      CE && REG_REQ.rd && REG_REQ.addr == RATE_OFS |=> !RD_DATA[5])
      else $error("rate shadow reserved bit read nonzero");

   ser1_read_a: assert property (
      CE && REG_REQ.rd && REG_REQ.addr == SER1_OFS
      |=> RD_DATA[5:4] == 2'h0)
      else $error("first serial shadow reserved bits read nonzero");

   ser1_hold_a: assert property (
      !(CE && SHADOW_WR.ser1_wr) |=> $stable(sh_q[1]))
      else $error("first serial shadow changed without its strobe");

   ser2_capture_a: assert property (
      CE && SHADOW_WR.ser2_wr
      |=> sh_q[2] == ($past(SHADOW_WR.data) & FIFO_MASK))
      else $error("second serial shadow not captured");

   kill_floppy_a: assert property (
      CE && kill_q[KILL_FN_LSB] |=> !FUNC_ENABLE[0])
      else $error("floppy still enabled when killed");

   kill_midi_a: assert property (
      CE && kill_q[KILL_FN_LSB + 1] |=> !FUNC_ENABLE[1])
      else $error("midi uart still enabled when killed");

   kill_ser1_a: assert property (
      CE && kill_q[KILL_FN_LSB + 3] |=> !FUNC_ENABLE[3])
      else $error("first serial still enabled when killed");

   kill_par_a: assert property (
      CE && kill_q[KILL_FN_LSB + 4] |=> !FUNC_ENABLE[4])
      else $error("parallel port still enabled when killed");

   par_pass_a: assert property (
      CE && !kill_q[KILL_FN_LSB + 4]
      |=> FUNC_ENABLE[4] == $past(ACTIVATE[4]))
      else $error("parallel enable does not follow activate bit");

   wp_pin_a: assert property (
      CE && wp_pin_s |=> WRITE_PROTECT_CORE)
      else $error("write protect pin not passed to core");

   wp_sel0_a: assert property (
      CE && drv_sel[0] && FORCE_WP |=> WRITE_PROTECT_CORE)
      else $error("forced write protect on drive 0 not applied");

   wp_sel1_a: assert property (
      CE && drv_sel[1] && FORCE_WP |=> WRITE_PROTECT_CORE)
      else $error("forced write protect on drive 1 not applied");

   kill_write_a: assert property (
      CE && REG_REQ.wr && REG_REQ.addr == KILL_OFS && !locked
      |=> kill_q == ($past(REG_REQ.wdata) & KILL_MASK))
      else $error("unlocked kill register write not taken");

   kill_hold_a: assert property (
      !(CE && kill_wr) |=> $stable(kill_q))
      else $error("kill register changed without a write");

   lock_flag_a: assert property (
      CE && locked |=> KILL_LOCKED)
      else $error("lock not reported");

   unlock_flag_a: assert property (
      CE && !locked |=> !KILL_LOCKED)
      else $error("lock reported while writable");
endmodule : floppy_override_device_disable_regs

// [hdl/pin_sync.sv]
// two-stage synchroniser for pin inputs
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import rt_regs_pkg::*;
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : pin_sync

// [hdl/rt_regs_pkg.sv]
// constants and carriers for the runtime override register slice
package rt_regs_pkg;
   localparam logic [7:0] FMC_OFS     = 8'h1E;
   localparam logic [7:0] RATE_OFS    = 8'h1F;
   localparam logic [7:0] SER1_OFS    = 8'h20;
   localparam logic [7:0] SER2_OFS    = 8'h21;
   localparam logic [7:0] KILL_OFS    = 8'h22;
   localparam logic [1:0] FMC_RST     = 2'h3;
   localparam logic [7:0] KILL_RST    = 8'h00;
   localparam logic [7:0] SHADOW_RST  = 8'h00;
   localparam logic [7:0] KILL_MASK   = 8'hF9;
   localparam logic [7:0] RATE_MASK   = 8'hDF;
   localparam logic [7:0] FIFO_MASK   = 8'hCF;
   localparam logic [1:0] LOCK_CFG_RO = 2'h1;
   localparam int         DRIVES      = 2;
   localparam int         FUNCS       = 5;
   localparam int         KILL_WP_BIT = 0;
   localparam int         KILL_FN_LSB = 3;
   localparam int         SHADOWS     = 3;
   localparam int         PIN_SYNCS   = 3;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic       rate_wr;
      logic       ser1_wr;
      logic       ser2_wr;
      logic [7:0] data;
   } shadow_wr_t;

   typedef struct packed {
      logic step_n;
      logic sel1_n;
      logic sel0_n;
   } drive_lines_t;
endpackage : rt_regs_pkg

// [hdl/shadow_reg.sv]
// read-only shadow of a byte written elsewhere
module shadow_reg #(
   parameter logic [7:0] MASK = 8'hFF
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       wr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] q
);
   import rt_regs_pkg::*;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= SHADOW_RST;
      end else if (ce && wr) begin
         q <= wdata & MASK;
      end
   end
endmodule : shadow_reg

// [sim/drive_side.sv]
// partner model: drive select and head step lines
module drive_side (
   input  wire logic                 clk,
   input  wire logic                 go,
   input  wire logic [1:0]           sel,
   output rt_regs_pkg::drive_lines_t lines
);
   timeunit 1ns;
   timeprecision 1ps;
   import rt_regs_pkg::*;
   logic step_n_q = 1'b1;
   // one-cycle step pulse while select is held
   always_ff @(posedge clk) begin
      step_n_q <= ~go;
   end
   assign lines = '{step_n: step_n_q, sel1_n: ~sel[1], sel0_n: ~sel[0]};
endmodule : drive_side

// [sim/floppy_override_device_disable_regs_bench.sv]
// testbench for the override and kill switch registers
module floppy_override_device_disable_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import rt_regs_pkg::*;
   logic         mclk = 0, rst_n = 0, stby_n = 0, go = 0, ce = 1;
   reg_req_t     req = '0;
   shadow_wr_t   shw = '0;
   drive_lines_t drv;
   logic [1:0]   sel = 0, lock_cfg = 0;
   logic         chg_n = 1, wp_n = 1, lock_pin = 0, fwp = 0;
   logic [4:0]   act = 5'h1F, fen;
   logic [7:0]   rd_data;
   logic         mcs, wpc, klock;
   int           err_total = 0, check_count = 0;

   always #4 mclk = ~mclk;

   drive_side partner (.clk(mclk), .go(go), .sel(sel), .lines(drv));

   floppy_override_device_disable_regs uut (
      .MCLK(mclk), .RESETN(rst_n), .STBY_RESETN(stby_n), .CE(ce),
      .REG_REQ(req), .RD_DATA(rd_data), .DRIVE(drv),
      .MEDIA_CHANGE_IN_N(chg_n), .WRITE_PROTECT_LINE_N(wp_n),
      .LOCK_CONTROL_PIN(lock_pin), .LOCK_CFG(lock_cfg),
      .FORCE_WP(fwp), .SHADOW_WR(shw), .ACTIVATE(act),
      .MEDIA_CHANGE_STATUS(mcs), .WRITE_PROTECT_CORE(wpc),
      .FUNC_ENABLE(fen), .KILL_LOCKED(klock));

   task end_sim;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      chk(rd_data, exp);
   endtask : rd

   task pick(input logic [1:0] s);
      @(posedge mclk);
      sel <= s;
      cyc(2);
   endtask : pick

   task step;
      @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      cyc(3);
   endtask : step

   task t_reset;
      rd(FMC_OFS, 8'h03);
      rd(KILL_OFS, 8'h00);
      rd(8'h30, 8'h00);
      chk({3'h0, fen}, 8'h1F);
   endtask : t_reset

   task t_change;
      wr(FMC_OFS, 8'h00);
      rd(FMC_OFS, 8'h03);
      pick(2'h1);
      chk(mcs, 1);
      step();
      rd(FMC_OFS, 8'h02);
      chk(mcs, 0);
      pick(2'h2);
      chk(mcs, 1);
      step();
      rd(FMC_OFS, 8'h00);
      chk(mcs, 0);
      @(posedge mclk);
      chg_n <= 1'b0;
      cyc(5);
      chk(mcs, 1);
      @(posedge mclk);
      chg_n <= 1'b1;
      wr(FMC_OFS, 8'h03);
      rd(FMC_OFS, 8'h03);
      pick(2'h0);
   endtask : t_change

   task t_shadow;
      @(posedge mclk);
      shw <= '{1'b1, 1'b0, 1'b0, 8'hFF};
      @(posedge mclk);
      shw <= '{1'b0, 1'b1, 1'b0, 8'h5A};
      @(posedge mclk);
      shw <= '{1'b0, 1'b0, 1'b1, 8'hF3};
      @(posedge mclk);
      shw <= '0;
      wr(RATE_OFS, 8'h00);
      rd(RATE_OFS, 8'hDF);
      rd(SER1_OFS, 8'h4A);
      rd(SER2_OFS, 8'hC3);
      @(posedge mclk);
      shw <= '{1'b1, 1'b0, 1'b0, 8'h3C};
      @(posedge mclk);
      shw <= '0;
      req <= '{RATE_OFS, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      chk(rd_data, 8'h1C);
   endtask : t_shadow

   task t_kill;
      for (int b = 3; b < 8; b++) begin
         wr(KILL_OFS, 8'h01 << b);
         cyc(2);
         chk({3'h0, fen}, 8'h1F & ~(8'h01 << (b - 3)));
      end
      wr(KILL_OFS, 8'hFF);
      rd(KILL_OFS, 8'hF9);
      chk({3'h0, fen}, 8'h00);
      chk(wpc, 1);
      wr(KILL_OFS, 8'h00);
      @(posedge mclk);
      fwp <= 1'b1;
      cyc(2);
      chk(wpc, 0);
      pick(2'h1);
      chk(wpc, 1);
      pick(2'h2);
      chk(wpc, 1);
      pick(2'h0);
      @(posedge mclk);
      fwp <= 1'b0;
      wp_n <= 1'b0;
      cyc(5);
      chk(wpc, 1);
      @(posedge mclk);
      wp_n <= 1'b1;
      cyc(5);
      chk(wpc, 0);
   endtask : t_kill

   task t_lock;
      @(posedge mclk);
      lock_cfg <= LOCK_CFG_RO;
      lock_pin <= 1'b1;
      cyc(5);
      chk(klock, 1);
      wr(KILL_OFS, 8'h08);
      rd(KILL_OFS, 8'h00);
      @(posedge mclk);
      lock_cfg <= 2'h2;
      cyc(2);
      wr(KILL_OFS, 8'h08);
      rd(KILL_OFS, 8'h08);
      @(posedge mclk);
      stby_n <= 1'b0;
      @(posedge mclk);
      stby_n <= 1'b1;
      rd(KILL_OFS, 8'h00);
   endtask : t_lock

   task t_freeze;
      @(posedge mclk);
      ce <= 1'b0;
      wr(KILL_OFS, 8'h08);
      @(posedge mclk);
      ce <= 1'b1;
      rd(KILL_OFS, 8'h00);
      chk({3'h0, fen}, 8'h1F);
   endtask : t_freeze

   initial begin
      #20us;
      err_total++;
      end_sim();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      stby_n <= 1'b1;
      cyc(2);
      t_reset();
      t_change();
      t_shadow();
      t_kill();
      t_lock();
      t_freeze();
      end_sim();
   end
endmodule : floppy_override_device_disable_regs_bench
